// ---- core/phap_cfg.svh ----
// constants for the palette host access port: offsets, fields, reset values, timing
`ifndef PHAP_CFG_SVH
`define PHAP_CFG_SVH

// select line codes
`define PHAP_SEL_PTR_PW   3'h0
`define PHAP_SEL_PAL_DATA 3'h1
`define PHAP_SEL_MASK     3'h2
`define PHAP_SEL_PTR_PR   3'h3
`define PHAP_SEL_PTR_OW   3'h4
`define PHAP_SEL_OVL_DATA 3'h5
`define PHAP_SEL_CMD      3'h6
`define PHAP_SEL_PTR_OR   3'h7

// command register field and reset, mask register reset and mask read count
`define PHAP_CMD_DIRECT_BIT 7
`define PHAP_CMD_RST        1'h0
`define PHAP_MASK_RST       8'hff
`define PHAP_MASK_READS     2'h3

// device pin sync vector reset: strobes idle high, mode pin high
`define PHAP_PINS_RST 16'h2300

// host control registers
`define PHAP_HREG_SEL    3'h0
`define PHAP_HREG_WRITE  3'h1
`define PHAP_HREG_READ   3'h2
`define PHAP_HREG_STATUS 3'h3
`define PHAP_HREG_PINS   3'h4
`define PHAP_HPINS_RST   3'h2

// link timing
`define PHAP_CLK_NS     10
`define PHAP_STROBE_NS  80
`define PHAP_GAP_NS     60
`define PHAP_STROBE_CYC ((`PHAP_STROBE_NS + `PHAP_CLK_NS - 1) / `PHAP_CLK_NS)
`define PHAP_GAP_CYC    ((`PHAP_GAP_NS + `PHAP_CLK_NS - 1) / `PHAP_CLK_NS)

`endif

// ---- core/phap_pkg.sv ----
// types for the palette host access port
package phap_pkg;

  typedef enum logic [2:0] {
    PHAP_IDLE   = 3'b001,
    PHAP_STROBE = 3'b010,
    PHAP_GAP    = 3'b100
  } phap_hst_e;

  typedef struct packed {
    logic       compact;
    logic       wide;
    logic       dcol_n;
    logic [2:0] rs;
    logic       wr_n;
    logic       rd_n;
    logic [7:0] d;
  } phap_pins_s;

  typedef struct packed {
    phap_pins_s sy1;
    phap_pins_s sy2;
    logic       wr_old;
    logic       rd_old;
    logic [7:0] ptr;
    logic [1:0] cc;
    logic       ovl;
    logic       pend;
    logic [23:0] hold;
    logic [15:0] wbuf;
    logic [7:0] mask;
    logic       cmd_direct;
    logic       flag;
    logic [1:0] mask_cnt;
    logic [7:0] dout;
    logic       doe;
    logic       xfer;
    logic [23:0] conv;
  } phap_dev_s;

  typedef struct packed {
    phap_hst_e  st;
    logic [3:0] cnt;
    logic [2:0] rs;
    logic       wr_n;
    logic       rd_n;
    logic [7:0] hd;
    logic       hoe;
    logic       is_rd;
    logic [7:0] sy1;
    logic [7:0] sy2;
    logic [7:0] rdata;
    logic [2:0] pins;
    logic [7:0] sw_rdata;
  } phap_hst_s;

endpackage

// ---- core/phap_if.sv ----
// parallel host bus between the microprocessor end and the palette end
interface phap_if;
  logic [2:0] register_select_lines;
  logic       wr_n;
  logic       rd_n;
  logic [7:0] host_d;
  logic       host_oe;
  logic [7:0] dev_d;
  logic       dev_oe;
  logic       wide_sel;
  logic       direct_colour_pin;
  logic       compact_sel;
  logic [7:0] dbus;

  // resolved data bus; floats high when nobody drives
  assign dbus = host_oe ? host_d : (dev_oe ? dev_d : 8'hff);

  modport host (
    output register_select_lines, wr_n, rd_n, host_d, host_oe,
    output wide_sel, direct_colour_pin, compact_sel,
    input  dbus
  );
  modport device (
    input  register_select_lines, wr_n, rd_n, dbus,
    input  wide_sel, direct_colour_pin, compact_sel,
    output dev_d, dev_oe
  );
endinterface

// ---- core/phap_host.sv ----
// microprocessor end: drives the select lines and strobes from software orders
`include "phap_cfg.svh"
module phap_host (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // software port
  input  wire logic [2:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  // palette bus
  phap_if.host            link
);
  import phap_pkg::*;

  phap_hst_s q;
  phap_hst_s n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    n.sy1 = link.dbus;
    n.sy2 = q.sy1;
    n.sw_rdata = 8'h00;
    if (sw_rd) begin
      unique case (sw_addr)
        `PHAP_HREG_SEL:    n.sw_rdata = {5'h00, q.rs};
        `PHAP_HREG_WRITE:  n.sw_rdata = q.rdata;
        `PHAP_HREG_STATUS: n.sw_rdata = {7'h00, q.st != PHAP_IDLE};
        `PHAP_HREG_PINS:   n.sw_rdata = {5'h00, q.pins};
        default:           n.sw_rdata = 8'h00;
      endcase
    end
    unique case (q.st)
      PHAP_IDLE: begin
        // orders are taken only when idle, so select lines never move under a strobe
        if (sw_wr) begin
          unique case (sw_addr)
            `PHAP_HREG_SEL: n.rs = sw_wdata[2:0];
            `PHAP_HREG_PINS: n.pins = sw_wdata[2:0];
            `PHAP_HREG_WRITE: begin
              n.hd = sw_wdata;
              n.hoe = 1'b1;
              n.wr_n = 1'b0;
              n.is_rd = 1'b0;
              n.cnt = 4'h0;
              n.st = PHAP_STROBE;
            end
            `PHAP_HREG_READ: begin
              n.rd_n = 1'b0;
              n.is_rd = 1'b1;
              n.cnt = 4'h0;
              n.st = PHAP_STROBE;
            end
            default: n.st = PHAP_IDLE;
          endcase
        end
      end
      PHAP_STROBE: begin
        n.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(`PHAP_STROBE_CYC - 1)) begin
          n.wr_n = 1'b1;
          n.rd_n = 1'b1;
          n.hoe = 1'b0;
          if (q.is_rd) begin
            n.rdata = q.sy2;
          end
          n.cnt = 4'h0;
          n.st = PHAP_GAP;
        end
      end
      PHAP_GAP: begin
        // the gap leaves the palette end room for its internal moves
        n.cnt = q.cnt + 4'h1;
        if (q.cnt == 4'(`PHAP_GAP_CYC - 1)) begin
          n.st = PHAP_IDLE;
        end
      end
      default: n.st = PHAP_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{st: PHAP_IDLE, cnt: 4'h0, rs: 3'h0, wr_n: 1'b1, rd_n: 1'b1, hd: 8'h00,
             hoe: 1'b0, is_rd: 1'b0, sy1: 8'h00, sy2: 8'h00, rdata: 8'h00,
             pins: `PHAP_HPINS_RST, sw_rdata: 8'h00};
    end else begin
      q <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign sw_rdata = q.sw_rdata;
  assign link.register_select_lines = q.rs;
  assign link.wr_n = q.wr_n;
  assign link.rd_n = q.rd_n;
  assign link.host_d = q.hd;
  assign link.host_oe = q.hoe;
  assign link.wide_sel = q.pins[0];
  assign link.direct_colour_pin = q.pins[1];
  assign link.compact_sel = q.pins[2];
endmodule

// ---- core/phap_dev.sv ----
// palette end: pointer, component counter, holding registers, palette and overlay store
`include "phap_cfg.svh"
module phap_dev (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // host bus
  phap_if.device           link,
  // pixel side
  input  wire logic [7:0]  pixel_index,
  input  wire logic [3:0]  overlay_select,
  output logic      [23:0] converter_rgb,
  output logic             direct_mode
);
  import phap_pkg::*;

  phap_dev_s q;
  phap_dev_s n;

  logic [23:0] pal_mem [256];
  logic [23:0] ovl_mem [16];

  logic        wr_go;
  logic        rd_go;
  logic [2:0]  sel;
  logic [7:0]  comp_in;
  logic [7:0]  comp_out;
  logic [23:0] fetch_rgb;
  logic [23:0] look_rgb;
  logic [7:0]  look_idx;
  logic        pal_we;
  logic        ovl_we;
  logic [23:0] st_rgb;

  ////////////////////////////////////////////////////////////////////////////
  // strobe edges seen after two synchroniser stages; the third stage is the history
  assign wr_go = q.wr_old & ~q.sy2.wr_n;
  assign rd_go = q.rd_old & ~q.sy2.rd_n;

  // the variant without the third select line sees it as zero
  assign sel = q.sy2.compact ? {1'b0, q.sy2.rs[1:0]} : q.sy2.rs;

  // 6-bit data sits left-aligned so the two low converter bits stay zero
  assign comp_in = q.sy2.wide ? q.sy2.d : {q.sy2.d[5:0], 2'h0};

  always_comb begin
    unique case (q.cc)
      2'h0:    comp_out = q.hold[23:16];
      2'h1:    comp_out = q.hold[15:8];
      default: comp_out = q.hold[7:0];
    endcase
  end

  // overlay index drops the upper nibble of the pointer
  assign fetch_rgb = q.ovl ? ovl_mem[q.ptr[3:0]] : pal_mem[q.ptr];
  assign st_rgb = {q.wbuf, comp_in};

  assign look_idx = pixel_index & q.mask;
  assign look_rgb = (overlay_select != 4'h0) ? ovl_mem[overlay_select] : pal_mem[look_idx];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = q;
    pal_we = 1'b0;
    ovl_we = 1'b0;
    n.sy1 = '{compact: link.compact_sel, wide: link.wide_sel,
              dcol_n: link.direct_colour_pin, rs: link.register_select_lines,
              wr_n: link.wr_n, rd_n: link.rd_n, d: link.dbus};
    n.sy2 = q.sy1;
    n.wr_old = q.sy2.wr_n;
    n.rd_old = q.sy2.rd_n;
    n.xfer = 1'b0;
    // data is driven for as long as the read strobe is seen low
    n.doe = ~q.sy2.rd_n;

    if (wr_go) begin
      // any write ends a run of mask reads
      n.flag = 1'b0;
      n.mask_cnt = 2'h0;
      unique case (sel)
        `PHAP_SEL_PTR_PW, `PHAP_SEL_PTR_PR, `PHAP_SEL_PTR_OW, `PHAP_SEL_PTR_OR: begin
          n.ptr = q.sy2.d;
          n.cc = 2'h0;
          n.ovl = sel[2];
          n.pend = sel[1] & sel[0];
        end
        `PHAP_SEL_PAL_DATA, `PHAP_SEL_OVL_DATA: begin
          unique case (q.cc)
            2'h0: begin
              n.wbuf[15:8] = comp_in;
              n.cc = 2'h1;
            end
            2'h1: begin
              n.wbuf[7:0] = comp_in;
              n.cc = 2'h2;
            end
            default: begin
              pal_we = ~sel[2];
              ovl_we = sel[2];
              n.xfer = 1'b1;
              n.ptr = q.ptr + 8'h01;
              n.cc = 2'h0;
            end
          endcase
        end
        `PHAP_SEL_MASK: begin
          if (q.flag) begin
            n.cmd_direct = q.sy2.d[`PHAP_CMD_DIRECT_BIT];
          end else begin
            n.mask = q.sy2.d;
          end
        end
        default: n.cmd_direct = q.sy2.d[`PHAP_CMD_DIRECT_BIT];
      endcase
    end else if (rd_go) begin
      unique case (sel)
        `PHAP_SEL_PTR_PW, `PHAP_SEL_PTR_PR, `PHAP_SEL_PTR_OW, `PHAP_SEL_PTR_OR: begin
          n.dout = q.ptr;
        end
        `PHAP_SEL_PAL_DATA, `PHAP_SEL_OVL_DATA: begin
          n.dout = q.sy2.wide ? comp_out : {2'h0, comp_out[7:2]};
          n.cc = (q.cc == 2'h2) ? 2'h0 : q.cc + 2'h1;
          n.pend = (q.cc == 2'h2);
        end
        `PHAP_SEL_MASK: n.dout = q.mask;
        default: n.dout = {q.cmd_direct, 7'h00};
      endcase
      // four mask reads in a row arm the redirect; anything else disarms it
      if (sel == `PHAP_SEL_MASK) begin
        if (q.mask_cnt == `PHAP_MASK_READS) begin
          n.flag = 1'b1;
        end else begin
          n.mask_cnt = q.mask_cnt + 2'h1;
        end
      end else begin
        n.flag = 1'b0;
        n.mask_cnt = 2'h0;
      end
    end else if (q.pend && q.sy2.rd_n && q.sy2.wr_n) begin
      // fetch only between host accesses
      n.hold = fetch_rgb;
      n.ptr = q.ptr + 8'h01;
      n.pend = 1'b0;
      n.xfer = 1'b1;
    end

    // a store or fetch this cycle holds the old colour on the converters
    if (!(n.xfer || q.xfer)) begin
      n.conv = look_rgb;
    end
    if (!q.sy2.wide) begin
      n.conv[17:16] = 2'h0;
      n.conv[9:8] = 2'h0;
      n.conv[1:0] = 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '{sy1: `PHAP_PINS_RST, sy2: `PHAP_PINS_RST, wr_old: 1'b1, rd_old: 1'b1,
             ptr: 8'h00, cc: 2'h0, ovl: 1'b0, pend: 1'b0, hold: 24'h000000,
             wbuf: 16'h0000, mask: `PHAP_MASK_RST, cmd_direct: `PHAP_CMD_RST,
             flag: 1'b0, mask_cnt: 2'h0, dout: 8'h00, doe: 1'b0, xfer: 1'b0,
             conv: 24'h000000};
    end else begin
      q <= n;
    end
  end

  // colour store has no reset; software loads it before use
  always_ff @(posedge ref_clk) begin
    if (pal_we) begin
      pal_mem[q.ptr] <= st_rgb;
    end
    if (ovl_we) begin
      ovl_mem[q.ptr[3:0]] <= st_rgb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.dev_d = q.dout;
  assign link.dev_oe = q.doe;
  assign converter_rgb = q.conv;
  // either the command bit or a low mode pin selects direct colour
  assign direct_mode = q.cmd_direct | ~q.sy2.dcol_n;
endmodule

// ---- tb/phap_chk.sv ----
// wire checker for the host bus joining the two ends
module phap_chk (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // host bus
  input wire logic [2:0] register_select_lines,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic       host_oe,
  input wire logic       dev_oe,
  input wire logic       wide_sel,
  input wire logic [7:0] dbus
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wr_pulse;
    (!wr_n) [*8] ##1 wr_n;
  endsequence
  sequence s_rd_pulse;
    (!rd_n) [*8] ##1 rd_n;
  endsequence
  sequence s_quiet;
    (wr_n && rd_n) [*6];
  endsequence
  a_strobe_excl: assert property (!(!wr_n && !rd_n))
    else $error("both strobes low");
  a_write_len: assert property ($fell(wr_n) |-> s_wr_pulse)
    else $error("write strobe length wrong");
  a_read_len: assert property ($fell(rd_n) |-> s_rd_pulse)
    else $error("read strobe length wrong");
  a_strobe_gap: assert property ($rose(wr_n) || $rose(rd_n) |-> s_quiet)
    else $error("strobe gap too short");
  a_host_drive: assert property (!wr_n |-> host_oe && !dev_oe)
    else $error("bus not driven by host on write");
  a_read_answer: assert property ($fell(rd_n) |-> ##[2:3] dev_oe)
    else $error("device did not answer read");
  a_read_release: assert property ($rose(rd_n) |-> ##[1:3] !dev_oe)
    else $error("device held bus after read");
  a_sel_stable: assert property (!wr_n && $past(!wr_n) |-> $stable(register_select_lines))
    else $error("select lines moved in strobe");
  a_six_top: assert property (dev_oe && !rd_n && !wide_sel && register_select_lines[0]
    && !register_select_lines[1] |-> dbus[7:6] == 2'b00)
    else $error("six-bit read top lines not zero");
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the palette host port, both ends joined
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, reset_n, sw_wr, sw_rd, direct_mode;
  logic [2:0]  sw_addr;
  logic [7:0]  sw_wdata, sw_rdata, pixel_index, rd;
  logic [3:0]  overlay_select;
  logic [23:0] converter_rgb, col;
  logic [31:0] lfsr_q;
  logic [23:0] exp_col [0:255];
  int          n_fail, num_checks;
  phap_if u_phap_if ();
  phap_host u_phap_host (.ref_clk(ref_clk), .reset_n(reset_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .link(u_phap_if));
  phap_dev u_phap_dev (.ref_clk(ref_clk), .reset_n(reset_n), .link(u_phap_if),
    .pixel_index(pixel_index), .overlay_select(overlay_select),
    .converter_rgb(converter_rgb), .direct_mode(direct_mode));
  phap_chk u_phap_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .register_select_lines(u_phap_if.register_select_lines), .wr_n(u_phap_if.wr_n),
    .rd_n(u_phap_if.rd_n), .host_oe(u_phap_if.host_oe), .dev_oe(u_phap_if.dev_oe),
    .wide_sel(u_phap_if.wide_sel), .dbus(u_phap_if.dbus));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [7:0] rnd();
    repeat (8) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q[7:0];
  endfunction
  // up: stored view with low bits zero, else bus view with top bits zero
  function automatic logic [23:0] six(input logic [23:0] c, input logic up);
    for (int k = 0; k < 3; k++)
      six[8*k +: 8] = up ? {c[8*k +: 6], 2'b00} : {2'b00, c[8*k +: 6]};
  endfunction
  task automatic sw_w(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // orders given while busy are dropped, so every link op waits here
  task automatic idle();
    logic [7:0] st;
    st = 8'h01;
    for (int i = 0; i < 40 && st[0] !== 1'b0; i++) sw_r(3'h3, st);
    chk("busy", st[0], 1'b0);
  endtask
  task automatic link_w(input logic [2:0] s, input logic [7:0] d);
    sw_w(3'h0, {5'h00, s});
    sw_w(3'h1, d);
    idle();
  endtask
  task automatic link_r(input logic [2:0] s, output logic [7:0] d);
    sw_w(3'h0, {5'h00, s});
    sw_w(3'h2, 8'h00);
    idle();
    sw_r(3'h1, d);
  endtask
  task automatic put_rgb(input logic [2:0] s, input logic [23:0] c);
    for (int k = 2; k >= 0; k--) link_w(s, c[8*k +: 8]);
  endtask
  task automatic get_rgb(input logic [2:0] s, input logic [23:0] e);
    for (int k = 2; k >= 0; k--) begin
      link_r(s, rd);
      chk("colour byte", rd, e[8*k +: 8]);
    end
  endtask
  task automatic pix(input logic [7:0] p, input logic [3:0] o, input logic [23:0] e);
    @(posedge ref_clk);
    pixel_index <= p;
    overlay_select <= o;
    repeat (6) @(posedge ref_clk);
    #1 chk("converter", converter_rgb, e);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    n_fail++;
    print_verdict();
  end
  initial begin
    reset_n = 1'b0;
    {sw_wr, sw_rd, sw_addr, sw_wdata, pixel_index, overlay_select} = '0;
    lfsr_q = 32'h44d8;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    link_r(3'h6, rd);
    chk("command reset", rd, 8'h00);
    chk("mode reset", direct_mode, 1'b0);
    sw_w(3'h4, 8'h03);
    link_w(3'h0, 8'hfe);
    link_w(3'h1, rnd());
    link_w(3'h0, 8'hfe);
    for (int i = 0; i < 3; i++) begin
      exp_col[8'(254 + i)] = {rnd(), rnd(), rnd()};
      put_rgb(3'h1, exp_col[8'(254 + i)]);
    end
    link_r(3'h0, rd);
    chk("pointer wrap", rd, 8'h01);
    link_r(3'h3, rd);
    chk("pointer reread", rd, 8'h01);
    link_w(3'h3, 8'hfe);
    get_rgb(3'h1, exp_col[254]);
    get_rgb(3'h1, exp_col[255]);
    get_rgb(3'h1, exp_col[0]);
    link_r(3'h0, rd);
    chk("pointer after reads", rd, 8'h02);
    pix(8'hff, 4'h0, exp_col[255]);
    sw_w(3'h4, 8'h02);
    col = {rnd(), rnd(), rnd()};
    link_w(3'h0, 8'h10);
    put_rgb(3'h1, col);
    link_w(3'h3, 8'h10);
    get_rgb(3'h1, six(col, 1'b0));
    pix(8'h10, 4'h0, six(col, 1'b1));
    sw_w(3'h4, 8'h03);
    col = {rnd(), rnd(), rnd()};
    link_w(3'h4, 8'h23);
    put_rgb(3'h5, col);
    link_r(3'h0, rd);
    chk("overlay pointer", rd, 8'h24);
    link_w(3'h7, 8'hf3);
    get_rgb(3'h5, col);
    pix(rnd(), 4'h3, col);
    link_w(3'h6, 8'h80);
    link_r(3'h6, rd);
    chk("command set", rd, 8'h80);
    chk("mode by command", direct_mode, 1'b1);
    link_w(3'h6, 8'h00);
    sw_w(3'h4, 8'h01);
    repeat (4) @(posedge ref_clk);
    #1 chk("mode by pin", direct_mode, 1'b1);
    sw_w(3'h4, 8'h03);
    for (int i = 0; i < 4; i++) begin
      link_r(3'h2, rd);
      chk("mask reset", rd, 8'hff);
    end
    link_w(3'h2, 8'h80);
    link_r(3'h6, rd);
    chk("redirected write", rd, 8'h80);
    print_verdict();
  end
endmodule
